//--- hdl/hrd_csum.sv
// running byte sum giving the two's complement checksum byte
`timescale 1ns/1ps
`default_nettype none
module hrd_csum (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic add_en,
    input wire logic [7:0] byte_in,
    output logic [7:0] csum
);
    logic [7:0] sum_q;

    // negated so the whole 512 byte block sums to zero
    assign csum = 8'(~sum_q + 8'h01);

    always_ff @(posedge clk) begin
        if (!rst_n || clear) begin
            sum_q <= 8'h00;
        end else if (add_en) begin
            sum_q <= 8'(sum_q + byte_in);
        end
    end
endmodule : hrd_csum
`default_nettype wire

//--- hdl/hrd_defs.svh
// constants of the health report data builder
`ifndef HRD_DEFS_SVH
`define HRD_DEFS_SVH

`define HRD_CMD_SMART 8'hb0
`define HRD_SUB_ATTR 8'hd0
`define HRD_SUB_THR 8'hd1
`define HRD_KEY 16'hc24f
`define HRD_REV 16'h0010
`define HRD_OFS_ENTRY_FIRST 10'd2
`define HRD_OFS_ENTRY_LAST 10'd361
`define HRD_ENTRY_LAST_BYTE 4'd11
`define HRD_THR_RSVD_FIRST 4'd2
`define HRD_OFS_OFFLINE 10'd362
`define HRD_OFS_SELFTEST 10'd363
`define HRD_OFS_TIME_LO 10'd364
`define HRD_OFS_TIME_HI 10'd365
`define HRD_OFS_OFF_CAP 10'd367
`define HRD_OFS_SMART_CAP_LO 10'd368
`define HRD_OFS_ERRLOG 10'd370
`define HRD_OFS_CHECKPOINT 10'd371
`define HRD_OFS_POLL_SHORT 10'd372
`define HRD_OFS_POLL_EXT 10'd373
`define HRD_OFS_CSUM 10'd511
`define HRD_OFF_CAP_BASE 8'h5b
`define HRD_OFF_CAP_ABORT_BIT 2
`define HRD_SMART_CAP_LO 8'h03
`define HRD_ERRLOG_CAP 8'h01
`define HRD_PCT_MAX 4'h9
`define HRD_WORDS_LAST 9'd255
`define HRD_FIFO_DEPTH 32
`define HRD_CLK_HZ 40000000
`define HRD_TICK_S 1
`define HRD_SEC_CYCLES (`HRD_CLK_HZ * `HRD_TICK_S)
`define HRD_SEC_PER_MIN 6'd59

`endif

//--- hdl/hrd_fifo.sv
// flop based word fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module hrd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    hrd_word_if.snk in_if,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_if.ready = (cnt_q != FULL);
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_if.valid && in_if.ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_if.data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule : hrd_fifo
`default_nettype wire

//--- hdl/hrd_pkg.sv
// types of the health report data builder
`default_nettype none
package hrd_pkg;

    typedef enum logic [2:0] {
        HRD_OFF_NEVER = 3'h0,
        HRD_OFF_DONE = 3'h2,
        HRD_OFF_RUNNING = 3'h3,
        HRD_OFF_SUSPENDED = 3'h4,
        HRD_OFF_HOST_ABORT = 3'h5,
        HRD_OFF_DEV_ABORT = 3'h6
    } hrd_offline_t;

    typedef enum logic [3:0] {
        HRD_ST_OK = 4'h0,
        HRD_ST_HOST_ABORT = 4'h1,
        HRD_ST_RESET = 4'h2,
        HRD_ST_FATAL = 4'h3,
        HRD_ST_FAIL_UNKNOWN = 4'h4,
        HRD_ST_FAIL_WRITE = 4'h5,
        HRD_ST_FAIL_SERVO = 4'h6,
        HRD_ST_FAIL_READ = 4'h7,
        HRD_ST_RUNNING = 4'hf
    } hrd_selftest_t;

    typedef enum logic [2:0] {
        HRD_IDLE = 3'b001,
        HRD_BUSY = 3'b010,
        HRD_XFER = 3'b100
    } hrd_state_t;

endpackage : hrd_pkg
`default_nettype wire

//--- hdl/hrd_top.sv
// health report data builder: smart value and threshold report generator
`timescale 1ns/1ps
`default_nettype none
`include "hrd_defs.svh"
module hrd_top #(
    parameter int SEC_CYCLES = `HRD_SEC_CYCLES,
    parameter int FIFO_DEPTH = `HRD_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] subcommand_select_field,
    input wire logic [15:0] cylinder_key_field,
    output logic bsy,
    output logic drq,
    output logic intrq,
    input wire logic status_rd,
    input wire logic pio_rd,
    output logic pio_rd_ready,
    output logic [15:0] pio_data,
    output logic [4:0] entry_idx,
    output logic [3:0] entry_byte_idx,
    output logic entry_is_thr,
    input wire logic [7:0] entry_byte,
    input wire hrd_pkg::hrd_offline_t offline_state,
    input wire logic auto_offline_en,
    input wire logic [15:0] offline_seconds,
    input wire logic abort_on_cmd,
    input wire hrd_pkg::hrd_selftest_t selftest_state,
    input wire logic [3:0] selftest_pct,
    input wire logic [7:0] selftest_checkpoint,
    input wire logic selftest_start,
    input wire logic selftest_is_ext,
    input wire logic [7:0] poll_short_min,
    input wire logic [7:0] poll_ext_min,
    output logic early_poll_abort,
    output logic early_poll_extend
);
    import hrd_pkg::*;

    // ------------------------------------------------------------
    // command acceptance and handshake
    // ------------------------------------------------------------
    hrd_state_t state_q;
    logic thr_q;
    logic bsy_q;
    logic drq_q;
    logic intrq_q;
    logic [8:0] words_out_q;
    logic accept;
    logic pop;
    logic fifo_valid;
    logic [15:0] fifo_data;

    hrd_word_if #(.WIDTH(16)) wr_if ();

    assign accept = (state_q == HRD_IDLE) && cmd_valid && (cmd_code == `HRD_CMD_SMART)
        && (cylinder_key_field == `HRD_KEY)
        && ((subcommand_select_field == `HRD_SUB_ATTR)
        || (subcommand_select_field == `HRD_SUB_THR));
    assign pop = drq_q && pio_rd && fifo_valid;
    assign pio_rd_ready = drq_q && fifo_valid;
    assign bsy = bsy_q;
    assign drq = drq_q;
    assign intrq = intrq_q;

    // ------------------------------------------------------------
    // byte generator
    // ------------------------------------------------------------
    logic [9:0] idx_q;
    logic gen_done_q;
    logic [7:0] lo_q;
    logic [4:0] entry_q;
    logic [3:0] eb_q;
    logic unused_q;
    logic gen_active;
    logic adv;
    logic in_entry;
    logic [7:0] cur_byte;
    logic [7:0] entry_val;
    logic [7:0] csum;
    logic [3:0] pct;

    assign gen_active = (state_q != HRD_IDLE) && !gen_done_q;
    // odd bytes wait for room: fifo back-pressure stalls the generator
    assign adv = gen_active && (!idx_q[0] || wr_if.ready);
    assign in_entry = (idx_q >= `HRD_OFS_ENTRY_FIRST) && (idx_q <= `HRD_OFS_ENTRY_LAST);
    assign wr_if.valid = gen_active && idx_q[0];
    assign wr_if.data = {cur_byte, lo_q};
    assign entry_idx = entry_q;
    assign entry_byte_idx = eb_q;
    assign entry_is_thr = thr_q;
    assign pct = (selftest_pct > `HRD_PCT_MAX) ? `HRD_PCT_MAX : selftest_pct;

    always_comb begin
        entry_val = entry_byte;
        if (eb_q != 4'h0) begin
            if (unused_q) begin
                entry_val = 8'h00;
            end else if (thr_q && (eb_q >= `HRD_THR_RSVD_FIRST)) begin
                entry_val = 8'h00;
            end else if (!thr_q && (eb_q == `HRD_ENTRY_LAST_BYTE)) begin
                entry_val = 8'h00;
            end
        end
    end

    always_comb begin
        cur_byte = 8'h00;
        if (idx_q == 10'd0) begin
            cur_byte = 8'(`HRD_REV & 16'h00ff);
        end else if (idx_q == 10'd1) begin
            cur_byte = 8'(`HRD_REV >> 8);
        end else if (in_entry) begin
            cur_byte = entry_val;
        end else if (idx_q == `HRD_OFS_CSUM) begin
            cur_byte = csum;
        end else if (!thr_q) begin
            unique case (idx_q)
                `HRD_OFS_OFFLINE: begin
                    cur_byte = {auto_offline_en, 4'h0, offline_state};
                end
                `HRD_OFS_SELFTEST: begin
                    cur_byte = {selftest_state, pct};
                end
                `HRD_OFS_TIME_LO: begin
                    cur_byte = offline_seconds[7:0];
                end
                `HRD_OFS_TIME_HI: begin
                    cur_byte = offline_seconds[15:8];
                end
                `HRD_OFS_OFF_CAP: begin
                    cur_byte = `HRD_OFF_CAP_BASE;
                    cur_byte[`HRD_OFF_CAP_ABORT_BIT] = abort_on_cmd;
                end
                `HRD_OFS_SMART_CAP_LO: begin
                    cur_byte = `HRD_SMART_CAP_LO;
                end
                `HRD_OFS_ERRLOG: begin
                    cur_byte = `HRD_ERRLOG_CAP;
                end
                `HRD_OFS_CHECKPOINT: begin
                    cur_byte = selftest_checkpoint;
                end
                `HRD_OFS_POLL_SHORT: begin
                    cur_byte = poll_short_min;
                end
                `HRD_OFS_POLL_EXT: begin
                    cur_byte = poll_ext_min;
                end
                default: begin
                    cur_byte = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || accept) begin
            idx_q <= 10'd0;
            gen_done_q <= 1'b0;
            entry_q <= 5'd0;
            eb_q <= 4'd0;
            unused_q <= 1'b0;
            lo_q <= 8'h00;
        end else if (adv) begin
            if (!idx_q[0]) begin
                lo_q <= cur_byte;
            end
            if (idx_q == `HRD_OFS_CSUM) begin
                gen_done_q <= 1'b1;
            end else begin
                idx_q <= idx_q + 10'd1;
            end
            if (in_entry) begin
                if (eb_q == 4'd0) begin
                    unused_q <= (entry_byte == 8'h00);
                end
                if (eb_q == `HRD_ENTRY_LAST_BYTE) begin
                    eb_q <= 4'd0;
                    entry_q <= entry_q + 5'd1;
                end else begin
                    eb_q <= eb_q + 4'd1;
                end
            end
        end
    end

    hrd_csum u_csum (
        .clk(core_clk),
        .rst_n(rst_n),
        .clear(accept),
        .add_en(adv && (idx_q != `HRD_OFS_CSUM)),
        .byte_in(cur_byte),
        .csum(csum)
    );

    hrd_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(core_clk),
        .rst_n(rst_n),
        .in_if(wr_if),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_data)
    );

    // ------------------------------------------------------------
    // task-file handshake state machine
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= HRD_IDLE;
            thr_q <= 1'b0;
            bsy_q <= 1'b0;
            drq_q <= 1'b0;
            intrq_q <= 1'b0;
            words_out_q <= 9'd0;
        end else begin
            if (status_rd) begin
                intrq_q <= 1'b0;
            end
            unique case (state_q)
                HRD_IDLE: begin
                    if (accept) begin
                        state_q <= HRD_BUSY;
                        thr_q <= (subcommand_select_field == `HRD_SUB_THR);
                        bsy_q <= 1'b1;
                        words_out_q <= 9'd0;
                    end
                end
                HRD_BUSY: begin
                    // buffer counts as loaded once the fifo is full or the block is done
                    if (!wr_if.ready || gen_done_q) begin
                        state_q <= HRD_XFER;
                        bsy_q <= 1'b0;
                        drq_q <= 1'b1;
                        intrq_q <= 1'b1;
                    end
                end
                HRD_XFER: begin
                    if (pop) begin
                        words_out_q <= words_out_q + 9'd1;
                        if (words_out_q == `HRD_WORDS_LAST) begin
                            state_q <= HRD_IDLE;
                            drq_q <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pio_data <= 16'h0000;
        end else if (pop) begin
            pio_data <= fifo_data;
        end
    end

    // ------------------------------------------------------------
    // self-test elapsed minutes and early polling
    // ------------------------------------------------------------
    localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1);
    logic [31:0] sec_cnt_q;
    logic [5:0] sec_q;
    logic [15:0] min_q;
    logic early;

    // minutes saturate, so a long test never looks early again
    always_ff @(posedge core_clk) begin
        if (!rst_n || selftest_start) begin
            sec_cnt_q <= 32'd0;
            sec_q <= 6'd0;
            min_q <= 16'd0;
        end else if (sec_cnt_q == SEC_LAST) begin
            sec_cnt_q <= 32'd0;
            if (sec_q == `HRD_SEC_PER_MIN) begin
                sec_q <= 6'd0;
                if (min_q != 16'hffff) begin
                    min_q <= min_q + 16'd1;
                end
            end else begin
                sec_q <= sec_q + 6'd1;
            end
        end else begin
            sec_cnt_q <= sec_cnt_q + 32'd1;
        end
    end

    assign early = accept && (subcommand_select_field == `HRD_SUB_ATTR)
        && (selftest_state == HRD_ST_RUNNING)
        && (min_q < {8'h00, (selftest_is_ext ? poll_ext_min : poll_short_min)});

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            early_poll_abort <= 1'b0;
            early_poll_extend <= 1'b0;
        end else begin
            early_poll_abort <= early && abort_on_cmd;
            early_poll_extend <= early && !abort_on_cmd;
        end
    end
endmodule : hrd_top
`default_nettype wire

//--- hdl/hrd_word_if.sv
// word stream carrier between the report builder and its fifo
`timescale 1ns/1ps
`default_nettype none
interface hrd_word_if #(parameter int WIDTH = 16);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : hrd_word_if
`default_nettype wire

//--- tb/hrd_host_model.sv
// host side model: data port reader that can stall between words
`timescale 1ns/1ps
`default_nettype none
module hrd_host_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic rd_en,
    input wire logic [3:0] gap,
    input wire logic pio_rd_ready,
    input wire logic [15:0] pio_data,
    output logic pio_rd
);
    logic [15:0] words [256];
    int unsigned n_words = 0;
    int unsigned wait_n = 0;
    logic take_q = 1'b0;
    initial pio_rd = 1'b0;
    // read data lands one cycle after the taken strobe
    always @(posedge core_clk) begin
        take_q <= pio_rd && pio_rd_ready;
        if (!rd_en) begin
            n_words <= 0;
        end else if (take_q) begin
            words[n_words[7:0]] <= pio_data;
            n_words <= n_words + 1;
        end
    end
    // strobe held until taken, then dropped for gap cycles to let the fifo fill
    always @(posedge core_clk) begin
        if (pio_rd && pio_rd_ready) begin
            wait_n = gap;
        end else if (wait_n != 0) begin
            wait_n = wait_n - 1;
        end
        pio_rd <= #1 rd_en && rst_n && (wait_n == 0);
    end
endmodule : hrd_host_model
`default_nettype wire

//--- tb/hrd_top_monitor.sv
// concurrent checks on the ports of the report builder
`timescale 1ns/1ps
`default_nettype none
`include "hrd_defs.svh"
module hrd_top_monitor #(
    parameter int SEC_CYCLES = `HRD_SEC_CYCLES,
    parameter int FIFO_DEPTH = `HRD_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] subcommand_select_field,
    input wire logic [15:0] cylinder_key_field,
    input wire logic bsy,
    input wire logic drq,
    input wire logic intrq,
    input wire logic status_rd,
    input wire logic pio_rd,
    input wire logic pio_rd_ready,
    input wire logic [15:0] pio_data,
    input wire logic abort_on_cmd,
    input wire logic early_poll_abort,
    input wire logic early_poll_extend
);
    logic acc, bad, take;
    logic [8:0] rd_cnt_q;
    assign acc = cmd_valid && cmd_code == `HRD_CMD_SMART && cylinder_key_field == `HRD_KEY
        && (subcommand_select_field == `HRD_SUB_ATTR || subcommand_select_field == `HRD_SUB_THR)
        && !bsy && !drq;
    assign bad = cmd_valid && !acc && !bsy && !drq;
    assign take = pio_rd && pio_rd_ready;
    // counts words of one transfer; cleared while the report is built
    always_ff @(posedge core_clk) begin
        if (!rst_n || bsy) begin
            rd_cnt_q <= 9'h000;
        end else if (take) begin
            rd_cnt_q <= rd_cnt_q + 9'h001;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_accept; acc |=> bsy; endproperty
    property p_refuse; bad |=> !bsy; endproperty
    property p_excl; !(bsy && drq); endproperty
    property p_ready; $fell(bsy) |-> drq && intrq; endproperty
    property p_bound; $rose(bsy) |-> ##[1:200] drq; endproperty
    property p_count; $fell(drq) |-> rd_cnt_q == 9'h100; endproperty
    property p_rdy_drq; pio_rd_ready |-> drq; endproperty
    property p_hold; !$past(take) |-> $stable(pio_data); endproperty
    property p_clr; status_rd && !bsy |=> !intrq; endproperty
    property p_abort; early_poll_abort |-> $past(abort_on_cmd) ##1 !early_poll_abort; endproperty
    property p_ext; early_poll_extend |-> !$past(abort_on_cmd) && !early_poll_abort; endproperty
    a_accept: assert property (p_accept) else $error("command not taken");
    a_refuse: assert property (p_refuse) else $error("bad command taken");
    a_excl: assert property (p_excl) else $error("busy with data request");
    a_ready: assert property (p_ready) else $error("busy fell without drq");
    a_bound: assert property (p_bound) else $error("report not ready");
    a_count: assert property (p_count) else $error("word count wrong");
    a_rdy_drq: assert property (p_rdy_drq) else $error("ready without drq");
    a_hold: assert property (p_hold) else $error("data moved");
    a_clr: assert property (p_clr) else $error("intrq not cleared");
    a_abort: assert property (p_abort) else $error("abort pulse wrong");
    a_ext: assert property (p_ext) else $error("extend pulse wrong");
    c_thr: cover property (acc && subcommand_select_field == `HRD_SUB_THR);
    c_done: cover property ($fell(drq));
    c_ext: cover property (early_poll_extend);
endmodule : hrd_top_monitor
bind hrd_top hrd_top_monitor #(.SEC_CYCLES(SEC_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) mon_u (
    .core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .subcommand_select_field(subcommand_select_field), .cylinder_key_field(cylinder_key_field),
    .bsy(bsy), .drq(drq), .intrq(intrq), .status_rd(status_rd), .pio_rd(pio_rd),
    .pio_rd_ready(pio_rd_ready), .pio_data(pio_data), .abort_on_cmd(abort_on_cmd),
    .early_poll_abort(early_poll_abort), .early_poll_extend(early_poll_extend));
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the health report data builder
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top;
    import hrd_pkg::*;
    logic core_clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, status_rd = 1'b0, rd_en = 1'b0;
    logic auto_offline_en = 1'b0, abort_on_cmd = 1'b0, selftest_start = 1'b0;
    logic selftest_is_ext = 1'b0, pio_rd, pio_rd_ready, entry_is_thr, bsy, drq, intrq;
    logic early_poll_abort, early_poll_extend;
    logic [3:0] gap = 4'h0, selftest_pct = 4'h0, entry_byte_idx;
    logic [4:0] entry_idx;
    logic [7:0] cmd_code = 8'h00, subcommand_select_field = 8'h00, entry_byte;
    logic [7:0] selftest_checkpoint = 8'h00, poll_short_min = 8'h00, poll_ext_min = 8'h00;
    logic [15:0] cylinder_key_field = 16'h0000, offline_seconds = 16'h0000, pio_data;
    hrd_offline_t offline_state = HRD_OFF_NEVER;
    hrd_selftest_t selftest_state = HRD_ST_OK;
    hrd_offline_t off_tab [6] = '{HRD_OFF_NEVER, HRD_OFF_DONE, HRD_OFF_RUNNING,
        HRD_OFF_SUSPENDED, HRD_OFF_HOST_ABORT, HRD_OFF_DEV_ABORT};
    hrd_selftest_t st_tab [9] = '{HRD_ST_OK, HRD_ST_HOST_ABORT, HRD_ST_RESET, HRD_ST_FATAL,
        HRD_ST_FAIL_UNKNOWN, HRD_ST_FAIL_WRITE, HRD_ST_FAIL_SERVO, HRD_ST_FAIL_READ, HRD_ST_RUNNING};
    logic [31:0] bad [3] = '{32'hecd0c24f, 32'hb0d2c24f, 32'hb0d04fc2};
    int err_total = 0, num_checks = 0, n_ab = 0, n_ex = 0, i;
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (early_poll_abort === 1'b1) n_ab++;
        if (early_poll_extend === 1'b1) n_ex++;
    end
    // entry store stand-in; ids 3 and 29 are unused slots
    function automatic logic [7:0] ent_id(input int e);
        case (e)
            0: return 8'h09;
            1: return 8'hc2;
            2: return 8'hc7;
            3, 29: return 8'h00;
            default: return 8'(e + 16);
        endcase
    endfunction : ent_id
    function automatic logic [7:0] ent_raw(input int e, input int b, input logic thr);
        return (b == 0) ? ent_id(e) : 8'(e * 7 + b * 13 + (thr ? 90 : 0));
    endfunction : ent_raw
    assign entry_byte = ent_raw(entry_idx, entry_byte_idx, entry_is_thr);
    function automatic logic [7:0] exp_byte(input int a, input logic thr);
        int e, b;
        e = (a - 2) / 12;
        b = (a - 2) % 12;
        if (a < 2) return (a == 0) ? 8'h10 : 8'h00;
        if (a <= 361) begin
            if (ent_id(e) == 8'h00 || (thr && b >= 2) || b == 11) return 8'h00;
            return ent_raw(e, b, thr);
        end
        if (thr) return 8'h00;
        case (a)
            362: return {auto_offline_en, 4'h0, offline_state};
            363: return {selftest_state, (selftest_pct > 4'h9) ? 4'h9 : selftest_pct};
            364: return offline_seconds[7:0];
            365: return offline_seconds[15:8];
            367: return 8'h5b | {5'h00, abort_on_cmd, 2'h0};
            368: return 8'h03;
            370: return 8'h01;
            371: return selftest_checkpoint;
            372: return poll_short_min;
            373: return poll_ext_min;
            default: return 8'h00;
        endcase
    endfunction : exp_byte
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask : tick
    task automatic wait_ok(input logic ok, input string nm);
        if (ok !== 1'b1) begin
            err_total++;
            $display("mismatch %s exp done got timeout", nm);
            give_verdict();
        end
    endtask : wait_ok
    // one-cycle task-file write; accepted on the edge after it is driven
    task automatic issue(input logic [7:0] c, input logic [7:0] s, input logic [15:0] k);
        tick();
        cmd_valid = 1'b1;
        cmd_code = c;
        subcommand_select_field = s;
        cylinder_key_field = k;
        tick();
        cmd_valid = 1'b0;
    endtask : issue
    task automatic read_report(input logic [7:0] sub, input logic [3:0] g, input logic poke);
        logic [7:0] lo, hi, sum;
        int n;
        sum = 8'h00;
        issue(8'hb0, sub, 16'hc24f);
        `CHK("bsy", 1'b1, bsy)
        for (n = 0; n < 400 && drq !== 1'b1; n++) tick();
        wait_ok(drq, "drq_wait");
        `CHK("bsy_done", 1'b0, bsy)
        `CHK("intrq", 1'b1, intrq)
        if (poke) begin
            issue(8'hb0, 8'hd0, 16'hc24f);
            `CHK("bsy_in_xfer", 1'b0, bsy)
        end
        gap = g;
        rd_en = 1'b1;
        for (n = 0; n < 3000 && host_u.n_words < 256; n++) tick();
        wait_ok(host_u.n_words == 256, "word_wait");
        `CHK("drq_end", 1'b0, drq)
        rd_en = 1'b0;
        for (n = 0; n < 256; n++) begin
            lo = exp_byte(2 * n, sub[0]);
            hi = (n == 255) ? 8'h00 - sum - lo : exp_byte(2 * n + 1, sub[0]);
            sum = sum + lo + hi;
            `CHK("report_word", {hi, lo}, host_u.words[n])
        end
        `CHK("intrq_held", 1'b1, intrq)
        status_rd = 1'b1;
        tick();
        status_rd = 1'b0;
        tick();
        `CHK("intrq_clr", 1'b0, intrq)
    endtask : read_report
    hrd_top #(.SEC_CYCLES(4), .FIFO_DEPTH(32)) dut_u (.core_clk, .rst_n, .cmd_valid, .cmd_code,
        .subcommand_select_field, .cylinder_key_field, .bsy, .drq, .intrq, .status_rd, .pio_rd,
        .pio_rd_ready, .pio_data, .entry_idx, .entry_byte_idx, .entry_is_thr, .entry_byte,
        .offline_state, .auto_offline_en, .offline_seconds, .abort_on_cmd, .selftest_state,
        .selftest_pct, .selftest_checkpoint, .selftest_start, .selftest_is_ext, .poll_short_min,
        .poll_ext_min, .early_poll_abort, .early_poll_extend);
    hrd_host_model host_u (.core_clk, .rst_n, .rd_en, .gap, .pio_rd_ready, .pio_data, .pio_rd);
    initial begin
        repeat (10) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        for (i = 0; i < 3; i++) begin
            issue(bad[i][31:24], bad[i][23:16], bad[i][15:0]);
            tick();
            `CHK("bsy_refused", 1'b0, bsy)
        end
        read_report(8'hd1, 4'h0, 1'b1);
        // host gaps of 0 to 3 cycles; the nonzero ones let the fifo fill and stall the builder
        for (i = 0; i < 9; i++) begin
            offline_state = off_tab[i % 6];
            selftest_state = st_tab[i];
            selftest_pct = 4'(i + 5);
            offline_seconds = 16'(16'h0e10 + i * 16'h0101);
            selftest_checkpoint = 8'(i * 17 + 3);
            poll_short_min = 8'(i + 1);
            poll_ext_min = 8'(i + 40);
            auto_offline_en = i[0];
            abort_on_cmd = i[1];
            selftest_is_ext = i[2];
            read_report(8'hd0, 4'(i % 4), 1'b0);
        end
        // host polls too early on purpose twice, then late once the extended poll time is zero
        poll_short_min = 8'h10;
        selftest_is_ext = 1'b0;
        abort_on_cmd = 1'b1;
        selftest_state = HRD_ST_RUNNING;
        selftest_start = 1'b1;
        tick();
        selftest_start = 1'b0;
        n_ab = 0;
        n_ex = 0;
        read_report(8'hd0, 4'h0, 1'b0);
        `CHK("abort_pulses", 1, n_ab)
        `CHK("extend_pulses", 0, n_ex)
        abort_on_cmd = 1'b0;
        read_report(8'hd0, 4'h0, 1'b0);
        `CHK("extend_pulses", 1, n_ex)
        selftest_is_ext = 1'b1;
        poll_ext_min = 8'h00;
        read_report(8'hd0, 4'h0, 1'b0);
        `CHK("extend_late", 1, n_ex)
        `CHK("abort_late", 1, n_ab)
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
